/* common/gbcpm_pkg.sv */
/*
  gbcpm_pkg: register indices, reset values, field positions and carrier
  types for the pin bank configuration and alternate-function block.
  Assumes a host configuration port with an index register and byte data.
*/
package gbcpm_pkg;

  // register indices held in the config index register
  localparam logic [7:0] IDX_BANK4_DIRECTION   = 8'h37;
  localparam logic [7:0] IDX_BANK4_POLARITY    = 8'h38;
  localparam logic [7:0] IDX_PIN_OUTPUT_TYPE   = 8'h39;
  localparam logic [7:0] IDX_ALT_FUNC_ONE      = 8'h40;
  localparam logic [7:0] IDX_ALT_FUNC_TWO      = 8'h41;

  // values after standby-supply power-on reset
  localparam logic [7:0] RST_BANK4_DIRECTION   = 8'h00;
  localparam logic [7:0] RST_BANK4_POLARITY    = 8'h80;
  localparam logic [7:0] RST_PIN_OUTPUT_TYPE   = 8'h00;
  localparam logic [7:0] RST_ALT_FUNC_ONE      = 8'h00;
  localparam logic [7:0] RST_ALT_FUNC_TWO      = 8'h00;

  // field positions
  localparam int ALT1_CS_LSB     = 0;
  localparam int ALT1_ADDR_LSB   = 3;
  localparam int ALT1_BANK1_LSB  = 6;
  localparam int OTYPE_WAKE_BIT  = 7;

  // bank1 pin0 selector encodings
  localparam logic [1:0] B1P0_GPIO     = 2'h0;
  localparam logic [1:0] B1P0_ADDR3    = 2'h1;
  localparam logic [1:0] B1P0_CS3      = 2'h2;
  localparam logic [1:0] B1P0_RESERVED = 2'h3;

  // host configuration access
  typedef struct packed {
    logic       cfg_state;
    logic       index_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } gbcpm_cfg_req_t;

  // expansion-bus signals from the bus engine
  typedef struct packed {
    logic [3:0] chip_sel_n;
    logic [3:0] addr;
    logic [7:0] data_out;
    logic       data_oe;
  } gbcpm_exp_t;

  // one bank of eight pins: from the core and toward the pads
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] pad_out;
    logic [7:0] pad_oe_n;
  } gbcpm_bank_t;

endpackage : gbcpm_pkg

/* verilog/gbcpm_bank_pad.sv */
/*
  gbcpm_bank_pad: registered pad logic for one eight-pin bank: chooses
  between gpio data and an alternate function, applies polarity and driver
  type. Assumes all inputs are synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module gbcpm_bank_pad #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // configuration
  input  wire logic [WIDTH-1:0] dir_in,
  input  wire logic [WIDTH-1:0] pol_in,
  input  wire logic [WIDTH-1:0] odrain_in,
  input  wire logic [WIDTH-1:0] alt_sel_in,
  // data sources
  input  wire logic [WIDTH-1:0] gpio_dout_in,
  input  wire logic [WIDTH-1:0] alt_dout_in,
  input  wire logic [WIDTH-1:0] alt_oe_in,
  // pad side, oe low means driven
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe_n_out
);

  logic [WIDTH-1:0] pad_d;
  logic [WIDTH-1:0] pad_q;
  logic [WIDTH-1:0] oe_n_d;
  logic [WIDTH-1:0] oe_n_q;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      logic lvl;
      logic drv;
      lvl = alt_sel_in[i] ? alt_dout_in[i] : (gpio_dout_in[i] ^ pol_in[i]);
      drv = alt_sel_in[i] ? (dir_in[i] & alt_oe_in[i]) : dir_in[i];
      // open drain only pulls low and floats for a high level
      pad_d[i]  = lvl;
      oe_n_d[i] = ~(drv & ~(odrain_in[i] & lvl));
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pad_q  <= '0;
      oe_n_q <= '1;
    end else begin
      pad_q  <= pad_d;
      oe_n_q <= oe_n_d;
    end
  end

  assign pad_out      = pad_q;
  assign pad_oe_n_out = oe_n_q;

endmodule : gbcpm_bank_pad
`default_nettype wire

/* verilog/gbcpm_top.sv */
/*
  gbcpm_top: configuration registers for bank 4 direction and polarity,
  driver types and alternate-function selects, plus the pin muxing they
  steer. Assumes reset_in is the standby-supply power-on reset and that all
  host and core inputs are synchronous to clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
module gbcpm_top (
  // clock and standby power-on reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // host configuration port
  input  wire gbcpm_pkg::gbcpm_cfg_req_t cfg_req_in,
  output logic [7:0]                  cfg_rdata_out,
  output logic                        cfg_rvalid_out,
  // core gpio data and expansion engine
  input  wire logic [7:0]             bank4_gpio_dout_in,
  input  wire logic [7:0]             bank3_gpio_dout_in,
  input  wire logic [7:0]             bank1_gpio_dout_in,
  input  wire logic [7:0]             bank3_dir_in,
  input  wire logic [7:0]             bank1_dir_in,
  input  wire logic                   bank2_pin0_dout_in,
  input  wire logic                   bank2_pin0_dir_in,
  input  wire logic                   wake_event_in,
  input  wire logic                   wake_polarity_in,
  input  wire gbcpm_pkg::gbcpm_exp_t  exp_in,
  // pads, oe low means driven
  output logic [7:0]                  bank4_pad_out,
  output logic [7:0]                  bank4_pad_oe_n_out,
  output logic [7:0]                  bank3_pad_out,
  output logic [7:0]                  bank3_pad_oe_n_out,
  output logic [7:0]                  bank1_pad_out,
  output logic [7:0]                  bank1_pad_oe_n_out,
  output logic                        bank2_pin0_pad_out,
  output logic                        bank2_pin0_pad_oe_n_out,
  output logic                        wake_event_out_n,
  output logic                        wake_event_oe_n_out,
  // configuration readback
  output logic [7:0]                  bank4_direction_out,
  output logic [7:0]                  bank4_polarity_out,
  output logic [7:0]                  pin_output_type_out,
  output logic [7:0]                  alt_function_select_one_out,
  output logic [7:0]                  alt_function_select_two_out
);

  logic [7:0] index_q, index_d;
  logic [7:0] dir4_q, dir4_d;
  logic [7:0] pol4_q, pol4_d;
  logic [7:0] otype_q, otype_d;
  logic [7:0] alt1_q, alt1_d;
  logic [7:0] alt2_q, alt2_d;
  logic [7:0] rdata_q, rdata_d;
  logic       rvalid_q, rvalid_d;
  logic [3:0] b2_d, b2_q;

  logic       wr;
  logic       rd;
  logic [1:0] b1p0_sel;
  logic [7:0] b4_alt_sel, b4_alt_dout, b4_alt_oe;
  logic [7:0] b1_alt_sel, b1_alt_dout, b1_odrain;

  // host writes and reads only in the configuration state
  assign wr = cfg_req_in.cfg_state & cfg_req_in.data_wr;
  assign rd = cfg_req_in.cfg_state & cfg_req_in.data_rd;

  always_comb begin
    index_d  = index_q;
    dir4_d   = dir4_q;
    pol4_d   = pol4_q;
    otype_d  = otype_q;
    alt1_d   = alt1_q;
    alt2_d   = alt2_q;
    rdata_d  = rdata_q;
    rvalid_d = 1'b0;
    if (cfg_req_in.cfg_state && cfg_req_in.index_wr) begin
      index_d = cfg_req_in.wdata;
    end
    if (wr) begin
      unique case (index_q)
        gbcpm_pkg::IDX_BANK4_DIRECTION: dir4_d  = cfg_req_in.wdata;
        gbcpm_pkg::IDX_BANK4_POLARITY:  pol4_d  = cfg_req_in.wdata;
        gbcpm_pkg::IDX_PIN_OUTPUT_TYPE: otype_d = cfg_req_in.wdata;
        gbcpm_pkg::IDX_ALT_FUNC_ONE:    alt1_d  = cfg_req_in.wdata;
        gbcpm_pkg::IDX_ALT_FUNC_TWO:    alt2_d  = cfg_req_in.wdata;
        default: ;
      endcase
    end
    if (rd) begin
      rvalid_d = 1'b1;
      unique case (index_q)
        gbcpm_pkg::IDX_BANK4_DIRECTION: rdata_d = dir4_q;
        gbcpm_pkg::IDX_BANK4_POLARITY:  rdata_d = pol4_q;
        gbcpm_pkg::IDX_PIN_OUTPUT_TYPE: rdata_d = otype_q;
        gbcpm_pkg::IDX_ALT_FUNC_ONE:    rdata_d = alt1_q;
        gbcpm_pkg::IDX_ALT_FUNC_TWO:    rdata_d = alt2_q;
        default:                        rdata_d = 8'h00;
      endcase
    end
  end

  // only the standby power-on reset reaches these registers
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      index_q  <= 8'h00;
      dir4_q   <= gbcpm_pkg::RST_BANK4_DIRECTION;
      pol4_q   <= gbcpm_pkg::RST_BANK4_POLARITY;
      otype_q  <= gbcpm_pkg::RST_PIN_OUTPUT_TYPE;
      alt1_q   <= gbcpm_pkg::RST_ALT_FUNC_ONE;
      alt2_q   <= gbcpm_pkg::RST_ALT_FUNC_TWO;
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      index_q  <= index_d;
      dir4_q   <= dir4_d;
      pol4_q   <= pol4_d;
      otype_q  <= otype_d;
      alt1_q   <= alt1_d;
      alt2_q   <= alt2_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // alternate function mapping for bank 4 and bank 1
  always_comb begin
    b1p0_sel    = alt1_q[gbcpm_pkg::ALT1_BANK1_LSB +: 2];
    b4_alt_sel  = 8'h00;
    b4_alt_dout = 8'h00;
    b4_alt_oe   = 8'hff;
    b4_alt_sel[2:0]  = alt1_q[gbcpm_pkg::ALT1_CS_LSB +: 3];
    b4_alt_dout[2:0] = exp_in.chip_sel_n[2:0];
    b4_alt_sel[7:5]  = alt1_q[gbcpm_pkg::ALT1_ADDR_LSB +: 3];
    b4_alt_dout[7:5] = exp_in.addr[2:0];
    b1_alt_sel  = 8'h00;
    b1_alt_dout = 8'h00;
    unique case (b1p0_sel)
      gbcpm_pkg::B1P0_GPIO:     b1_alt_sel[0] = 1'b0;
      gbcpm_pkg::B1P0_ADDR3: begin
        b1_alt_sel[0]  = 1'b1;
        b1_alt_dout[0] = exp_in.addr[3];
      end
      gbcpm_pkg::B1P0_CS3: begin
        b1_alt_sel[0]  = 1'b1;
        b1_alt_dout[0] = exp_in.chip_sel_n[3];
      end
      gbcpm_pkg::B1P0_RESERVED: b1_alt_sel[0] = 1'b0;
    endcase
    // bank1 pins 2..7 take driver type from bits 0..5
    b1_odrain = {otype_q[5:0], 2'b00};
  end

  // bank 2 pin 0 and wake pin
  always_comb begin
    logic lvl;
    logic lvl_w;
    lvl   = bank2_pin0_dout_in;
    // non-inverted wake polarity gives an active low output
    lvl_w = ~(wake_event_in ^ wake_polarity_in);
    b2_d[0] = lvl;
    b2_d[1] = ~(bank2_pin0_dir_in & ~(otype_q[6] & lvl));
    b2_d[2] = lvl_w;
    // open drain releases the wake pin for a high level
    b2_d[3] = otype_q[gbcpm_pkg::OTYPE_WAKE_BIT] & lvl_w;
  end

  // pads released, levels low, wake output idle high
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      b2_q <= 4'he;
    end else begin
      b2_q <= b2_d;
    end
  end

  // direction per pin steers the bank 4 drivers
  gbcpm_bank_pad #(.WIDTH(8)) u_bank4 (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .dir_in       (dir4_q),
    .pol_in       (pol4_q),
    .odrain_in    (8'h00),
    .alt_sel_in   (b4_alt_sel),
    .gpio_dout_in (bank4_gpio_dout_in),
    .alt_dout_in  (b4_alt_dout),
    .alt_oe_in    (b4_alt_oe),
    .pad_out      (bank4_pad_out),
    .pad_oe_n_out (bank4_pad_oe_n_out)
  );

  gbcpm_bank_pad #(.WIDTH(8)) u_bank3 (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .dir_in       (bank3_dir_in),
    .pol_in       (8'h00),
    .odrain_in    (8'h00),
    .alt_sel_in   (alt2_q),
    .gpio_dout_in (bank3_gpio_dout_in),
    .alt_dout_in  (exp_in.data_out),
    .alt_oe_in    ({8{exp_in.data_oe}}),
    .pad_out      (bank3_pad_out),
    .pad_oe_n_out (bank3_pad_oe_n_out)
  );

  gbcpm_bank_pad #(.WIDTH(8)) u_bank1 (
    .clk_in       (clk_in),
    .reset_in     (reset_in),
    .dir_in       (bank1_dir_in),
    .pol_in       (8'h00),
    .odrain_in    (b1_odrain),
    .alt_sel_in   (b1_alt_sel),
    .gpio_dout_in (bank1_gpio_dout_in),
    .alt_dout_in  (b1_alt_dout),
    .alt_oe_in    (8'hff),
    .pad_out      (bank1_pad_out),
    .pad_oe_n_out (bank1_pad_oe_n_out)
  );

  assign bank2_pin0_pad_out          = b2_q[0];
  assign bank2_pin0_pad_oe_n_out     = b2_q[1];
  assign wake_event_out_n            = b2_q[2];
  assign wake_event_oe_n_out         = b2_q[3];
  assign cfg_rdata_out               = rdata_q;
  assign cfg_rvalid_out              = rvalid_q;
  assign bank4_direction_out         = dir4_q;
  assign bank4_polarity_out          = pol4_q;
  assign pin_output_type_out         = otype_q;
  assign alt_function_select_one_out = alt1_q;
  assign alt_function_select_two_out = alt2_q;

endmodule : gbcpm_top
`default_nettype wire

/* testbench/gbcpm_top_properties.sv */
/*
  gbcpm_top_properties: port checker for gbcpm_top, bound by name.
  assumes registered outputs and one-cycle read strobe as handed over.
*/
`timescale 1ns/1ps
`default_nettype none
module gbcpm_checker (
  input wire logic                      clk_in,
  input wire logic                      reset_in,
  input wire gbcpm_pkg::gbcpm_cfg_req_t cfg_req_in,
  input wire logic [7:0]                cfg_rdata_out,
  input wire logic                      cfg_rvalid_out,
  input wire logic [7:0]                bank4_gpio_dout_in,
  input wire logic                      wake_event_in,
  input wire logic                      wake_polarity_in,
  input wire gbcpm_pkg::gbcpm_exp_t     exp_in,
  input wire logic [7:0]                bank4_pad_out,
  input wire logic [7:0]                bank4_pad_oe_n_out,
  input wire logic                      wake_event_out_n,
  input wire logic                      wake_event_oe_n_out,
  input wire logic [7:0]                bank4_direction_out,
  input wire logic [7:0]                bank4_polarity_out,
  input wire logic [7:0]                pin_output_type_out,
  input wire logic [7:0]                alt_function_select_one_out
);
  wire logic wr = cfg_req_in.cfg_state & cfg_req_in.data_wr;
  wire logic rd = cfg_req_in.cfg_state & cfg_req_in.data_rd;
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  // shadow of the index register
  always_comb idx_d = (cfg_req_in.cfg_state && cfg_req_in.index_wr) ? cfg_req_in.wdata : idx_q;
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) idx_q <= 8'h00;
    else idx_q <= idx_d;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  chk_dir_write: assert property (wr && idx_q == 8'h37 |=>
    bank4_direction_out == $past(cfg_req_in.wdata)) else $error("direction write lost");
  chk_pol_write: assert property (wr && idx_q == 8'h38 |=>
    bank4_polarity_out == $past(cfg_req_in.wdata)) else $error("polarity write lost");
  chk_hold_regs: assert property (!wr |=>
    $stable({bank4_direction_out, bank4_polarity_out})) else $error("register moved");
  chk_read_strobe: assert property (1'b1 |=>
    cfg_rvalid_out == $past(rd)) else $error("read strobe wrong");
  chk_read_other: assert property (rd && !(idx_q inside {[8'h37:8'h39], [8'h40:8'h41]}) |=>
    cfg_rdata_out == 8'h00) else $error("unmapped read not zero");
  chk_b4_input: assert property (!$past(reset_in) && !$past(bank4_direction_out[3]) |->
    bank4_pad_oe_n_out[3]) else $error("input pin driven");
  chk_b4_level: assert property (!$past(reset_in) && $past(bank4_direction_out[3]) |->
    bank4_pad_out[3] == ($past(bank4_gpio_dout_in[3]) ^ $past(bank4_polarity_out[3])))
    else $error("bank4 level wrong");
  chk_cs_mux: assert property (!$past(reset_in) && $past(alt_function_select_one_out[0]) &&
    $past(bank4_direction_out[0]) |-> bank4_pad_out[0] == $past(exp_in.chip_sel_n[0]))
    else $error("chip select not muxed");
  chk_wake_level: assert property (!$past(reset_in) |->
    wake_event_out_n == ($past(wake_event_in) ~^ $past(wake_polarity_in))) else $error("wake level");
  chk_wake_drive: assert property (!$past(reset_in) |->
    wake_event_oe_n_out == ($past(pin_output_type_out[7]) & wake_event_out_n))
    else $error("wake driver type");
  cov_read: cover property (rd);
  cov_alt_write: cover property (wr && idx_q == 8'h40);
  cov_wake: cover property (!wake_event_out_n);
endmodule : gbcpm_checker
bind gbcpm_top gbcpm_checker i_gbcpm_checker (.clk_in, .reset_in, .cfg_req_in, .cfg_rdata_out,
  .cfg_rvalid_out, .bank4_gpio_dout_in, .wake_event_in, .wake_polarity_in, .exp_in,
  .bank4_pad_out, .bank4_pad_oe_n_out, .wake_event_out_n, .wake_event_oe_n_out,
  .bank4_direction_out, .bank4_polarity_out, .pin_output_type_out, .alt_function_select_one_out);
`default_nettype wire

/* testbench/gbcpm_pin_model.sv */
/*
  gbcpm_pin_model: external bank-4 wires with board pull-ups.
  assumes oe low means the device drives the pin.
*/
`timescale 1ns/1ps
`default_nettype none
module gbcpm_pin_model (
  input  wire logic [7:0] pad_in,
  input  wire logic [7:0] oe_n_in,
  output logic      [7:0] level_out
);
  // released pins float up to the pull-up
  always_comb level_out = (pad_in & ~oe_n_in) | oe_n_in;
endmodule : gbcpm_pin_model
`default_nettype wire

/* testbench/gbcpm_top_bench.sv */
/*
  gbcpm_top_bench: self-checking bench for gbcpm_top.
  assumes the pin model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module gbcpm_top_bench;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  gbcpm_pkg::gbcpm_cfg_req_t req = '0;
  gbcpm_pkg::gbcpm_exp_t exp_bus = '0;
  logic [7:0] b4_dout = '0, b3_dout = '0, b1_dout = '0, b3_dir = '0, b1_dir = '0;
  logic b2_dout = 1'b0, b2_dir = 1'b0, wake = 1'b0, wake_pol = 1'b0;
  logic [7:0] rdata, b4_pad, b4_oe_n, b3_pad, b3_oe_n, b1_pad, b1_oe_n, b4_wire, alt2_reg;
  logic rvalid, b2_pad, b2_oe_n, wake_n, wake_oe_n;
  int miscompares = 0, comparisons = 0;
  always #2 clk_in = ~clk_in;
  gbcpm_top i_gbcpm_top (.clk_in(clk_in), .reset_in(reset_in), .cfg_req_in(req),
    .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .bank4_gpio_dout_in(b4_dout),
    .bank3_gpio_dout_in(b3_dout), .bank1_gpio_dout_in(b1_dout), .bank3_dir_in(b3_dir),
    .bank1_dir_in(b1_dir), .bank2_pin0_dout_in(b2_dout), .bank2_pin0_dir_in(b2_dir),
    .wake_event_in(wake), .wake_polarity_in(wake_pol), .exp_in(exp_bus),
    .bank4_pad_out(b4_pad), .bank4_pad_oe_n_out(b4_oe_n), .bank3_pad_out(b3_pad),
    .bank3_pad_oe_n_out(b3_oe_n), .bank1_pad_out(b1_pad), .bank1_pad_oe_n_out(b1_oe_n),
    .bank2_pin0_pad_out(b2_pad), .bank2_pin0_pad_oe_n_out(b2_oe_n),
    .wake_event_out_n(wake_n), .wake_event_oe_n_out(wake_oe_n),
    .bank4_direction_out(), .bank4_polarity_out(), .pin_output_type_out(),
    .alt_function_select_one_out(), .alt_function_select_two_out(alt2_reg));
  gbcpm_pin_model i_gbcpm_pin_model (.pad_in(b4_pad), .oe_n_in(b4_oe_n), .level_out(b4_wire));
  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    comparisons++;
    if (got !== want) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : chk
  task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val);
    @(posedge clk_in) req <= '{1'b1, 1'b1, 1'b0, 1'b0, idx};
    @(posedge clk_in) req <= '{1'b1, 1'b0, 1'b1, 1'b0, val};
    @(posedge clk_in) req <= '{1'b1, 1'b0, 1'b0, 1'b0, val};
  endtask : cfg_write
  task automatic cfg_read(input logic [7:0] idx, input logic [7:0] want);
    @(posedge clk_in) req <= '{1'b1, 1'b1, 1'b0, 1'b0, idx};
    @(posedge clk_in) req <= '{1'b1, 1'b0, 1'b0, 1'b1, 8'h00};
    @(posedge clk_in) req <= '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00};
    #1 chk({7'h00, rvalid}, 8'h01, "read strobe");
    chk(rdata, want, "read data");
  endtask : cfg_read
  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle
  task automatic t_registers;
    logic [7:0] idx [6] = '{8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h42};
    logic [7:0] val [6] = '{8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'h96, 8'h00};
    for (int i = 0; i < 5; i++) cfg_write(idx[i], val[i]);
    cfg_write(8'h42, 8'hff);
    for (int i = 0; i < 6; i++) cfg_read(idx[i], val[i]);
  endtask : t_registers
  task automatic t_gate;
    @(posedge clk_in) req <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h37};
    @(posedge clk_in) req <= '{1'b0, 1'b0, 1'b1, 1'b0, 8'hff};
    @(posedge clk_in) req <= '0;
    cfg_read(8'h37, 8'h00);
    cfg_read(8'h40, 8'h00);
  endtask : t_gate
  task automatic t_bank4;
    cfg_write(8'h37, 8'hff);
    cfg_write(8'h40, 8'h00);
    cfg_write(8'h38, 8'h0f);
    @(posedge clk_in) b4_dout <= 8'h55;
    settle();
    chk(b4_pad, 8'h5a, "bank4 level");
    chk(b4_wire, 8'h5a, "bank4 wire");
    cfg_write(8'h37, 8'h00);
    settle();
    chk(b4_oe_n, 8'hff, "bank4 inputs");
    chk(b4_wire, 8'hff, "bank4 pull-up");
  endtask : t_bank4
  task automatic t_alt;
    @(posedge clk_in) exp_bus <= '{4'h2, 4'hd, 8'h3c, 1'b1};
    b1_dir <= 8'hf1;
    b1_dout <= 8'h31;
    b3_dir <= 8'hff;
    b3_dout <= 8'h0f;
    b4_dout <= 8'h00;
    cfg_write(8'h39, 8'h3c);
    cfg_write(8'h37, 8'hff);
    cfg_write(8'h38, 8'h00);
    cfg_write(8'h40, 8'hbf);
    cfg_write(8'h41, 8'hf0);
    settle();
    chk(b4_pad, 8'ha2, "bank4 alternates");
    chk(b3_pad, 8'h3f, "bank3 data");
    chk(b3_oe_n, 8'h00, "bank3 drive");
    chk(alt2_reg, 8'hf0, "alt two contents");
    chk({7'h00, b1_pad[0]}, 8'h00, "chip select 3");
    chk(b1_oe_n, 8'h3e, "bank1 driver type");
    // gpio level now differs from address bit 3
    @(posedge clk_in) b1_dout <= 8'h30;
    cfg_write(8'h40, 8'h40);
    settle();
    chk({7'h00, b1_pad[0]}, 8'h01, "address 3");
    chk(b4_pad, 8'h00, "bank4 back to gpio");
    @(posedge clk_in) exp_bus <= '{4'ha, 4'h5, 8'h3c, 1'b0};
    cfg_write(8'h40, 8'hc0);
    settle();
    chk({7'h00, b1_pad[0]}, 8'h00, "reserved code");
    chk(b3_oe_n, 8'hf0, "bank3 data release");
  endtask : t_alt
  task automatic t_wake;
    logic [1:0] ev [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
    logic [1:0] res [4] = '{2'b00, 2'b11, 2'b00, 2'b11};
    cfg_write(8'h39, 8'h80);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in) {wake, wake_pol} <= ev[i];
      settle();
      chk({6'h00, wake_n, wake_oe_n}, {6'h00, res[i]}, "wake pin");
    end
    @(posedge clk_in) {b2_dout, b2_dir} <= 2'b11;
    settle();
    chk({6'h00, b2_pad, b2_oe_n}, 8'h02, "bank2 push-pull");
    cfg_write(8'h39, 8'hc0);
    settle();
    chk({6'h00, b2_pad, b2_oe_n}, 8'h03, "bank2 open drain");
  endtask : t_wake
  task automatic t_standby_reset;
    cfg_write(8'h37, 8'h5a);
    cfg_write(8'h38, 8'h01);
    cfg_write(8'h40, 8'hff);
    @(posedge clk_in) reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    cfg_read(8'h37, 8'h00);
    cfg_read(8'h38, 8'h80);
    cfg_read(8'h40, 8'h00);
  endtask : t_standby_reset
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    t_standby_reset();
    t_gate();
    t_registers();
    t_bank4();
    t_alt();
    t_wake();
    print_verdict();
  end
endmodule : gbcpm_top_bench
`default_nettype wire
